// ===== clkgen_ctrl.sv
// serial control, strap latch, output gating and watchdog fall-back
`timescale 1ns/1ps
module clkgen_ctrl import clkgen_pkg::*; #(
    parameter int PULSE_CYC = WDOG_PULSE_CYC,
    parameter logic [3:0] REV_ID = 4'h5,
    parameter logic [3:0] VENDOR_ID = 4'hA
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE_N,
    input wire logic [3:0] I_STRAP,
    input wire logic I_MODE,
    input wire logic I_PIN2,
    input wire logic [N_SRC-1:0] I_SRC_CLK,
    input wire logic I_WDOG_EXPIRE,
    output logic [N_OUT-1:0] O_CLK,
    output logic [N_OUT-1:0] O_CLK_OE_N,
    output logic O_WDOG_RESET_N,
    output logic O_WDOG_RESET_N_OE_N,
    output freq_t O_FREQ,
    output logic O_SPREAD,
    output logic signed [12:0] O_CPU_OFS
);
    // identity values are arbitrary
    localparam int PW = $clog2(PULSE_CYC + 1);
    if (PULSE_CYC < 2) begin : g_chk
        $error("PULSE_CYC too small");
    end

    logic [N_SRC+7:0] sync1_ff, sync2_ff;
    logic scl_d_ff, sda_d_ff;
    logic scl_s, sda_s, pin2_s;
    logic [N_SRC-1:0] src_s;
    strap_t strap_s, strap_ff;
    logic strap_done_ff;
    logic [1:0] strap_cnt_ff;
    logic start, stop, scl_rise, scl_fall, wr, fire, halt;
    i2c_st_t st_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff;
    logic rd_ff, nack_ff, sda_oe_n_ff, sda_out_ff;
    logic [2:0] idx_ff;
    logic [1:0] wcnt_ff;
    logic [7:0] regs_ff [N_REG];
    logic [7:0] reg_rd [N_REG];
    logic [7:0] rd_data;
    fb_st_t fb_ff;
    logic [PW-1:0] pulse_ff, nxt_pulse;
    logic wd_oe_n_ff, wd_out_ff;
    freq_t freq_ff, nxt_freq;
    logic spread_ff;
    logic signed [12:0] ofs_ff;
    logic [12:0] mag_ofs;
    logic [N_OUT-1:0] en_req, src_vec, clk_q, oe_q;

    // pins pass two flops; edge detect only reads the second stage
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            sync1_ff <= {3'h7, 1'b0, STRAP_PULL, 6'h00};
            sync2_ff <= {3'h7, 1'b0, STRAP_PULL, 6'h00};
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            sync1_ff <= {I_SCL, I_SDA, I_PIN2, I_MODE, I_STRAP, I_SRC_CLK};
            sync2_ff <= sync1_ff;
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end
    assign {scl_s, sda_s, pin2_s} = sync2_ff[N_SRC+7:N_SRC+5];
    assign strap_s = sync2_ff[N_SRC+4:N_SRC];
    assign src_s = sync2_ff[N_SRC-1:0];
    assign start = scl_s & sda_d_ff & ~sda_s;
    assign stop = scl_s & ~sda_d_ff & sda_s;
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;

    // wait for the synchroniser to fill before catching the straps
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            strap_cnt_ff <= 2'h0;
            strap_done_ff <= 1'b0;
            strap_ff <= '0;
        end else if (!strap_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == 2'(STRAP_WAIT)) begin
                strap_ff <= strap_s;
                strap_done_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            st_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            rd_ff <= 1'b0;
            nack_ff <= 1'b0;
            idx_ff <= 3'h0;
            wcnt_ff <= 2'h0;
            sda_oe_n_ff <= 1'b1;
        end else if (start) begin
            st_ff <= ST_ADDR;
            cnt_ff <= 4'h0;
            idx_ff <= 3'h0;
            wcnt_ff <= 2'h0;
            sda_oe_n_ff <= 1'b1;
        end else if (stop) begin
            st_ff <= ST_IDLE;
            sda_oe_n_ff <= 1'b1;
        end else if (scl_rise) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (st_ff == ST_ADDR || st_ff == ST_RX) begin
                sh_ff <= {sh_ff[6:0], sda_s};
            end
            if (st_ff == ST_TXACK) begin
                nack_ff <= sda_s;
            end
        end else if (scl_fall) begin
            unique case (st_ff)
                ST_IDLE: begin
                end
                ST_ADDR: if (cnt_ff == 4'h8) begin
                    if (sh_ff[7:1] == SLAVE_ADDR) begin
                        st_ff <= ST_AACK;
                        rd_ff <= sh_ff[0];
                        sda_oe_n_ff <= 1'b0;
                    end else begin
                        st_ff <= ST_IDLE;
                    end
                end
                ST_AACK: begin
                    cnt_ff <= 4'h0;
                    st_ff <= rd_ff ? ST_TX : ST_RX;
                    sh_ff <= rd_data;
                    sda_oe_n_ff <= rd_ff ? rd_data[7] : 1'b1;
                end
                ST_RX: if (cnt_ff == 4'h8) begin
                    st_ff <= ST_RXACK;
                    sda_oe_n_ff <= 1'b0;
                    // command and count bytes are taken but ignored
                    if (wcnt_ff == 2'h2) begin
                        idx_ff <= idx_ff + 3'h1;
                    end else begin
                        wcnt_ff <= wcnt_ff + 2'h1;
                    end
                end
                ST_RXACK: begin
                    st_ff <= ST_RX;
                    cnt_ff <= 4'h0;
                    sda_oe_n_ff <= 1'b1;
                end
                ST_TX: if (cnt_ff == 4'h8) begin
                    st_ff <= ST_TXACK;
                    sda_oe_n_ff <= 1'b1;
                    idx_ff <= idx_ff + 3'h1;
                end else begin
                    sh_ff <= {sh_ff[6:0], 1'b0};
                    sda_oe_n_ff <= sh_ff[6];
                end
                ST_TXACK: if (nack_ff) begin
                    st_ff <= ST_IDLE;
                end else begin
                    st_ff <= ST_TX;
                    cnt_ff <= 4'h0;
                    sh_ff <= rd_data;
                    sda_oe_n_ff <= rd_data[7];
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge I_CLK) begin
        sda_out_ff <= 1'b0;
    end
    assign wr = scl_fall && st_ff == ST_RX && cnt_ff == 4'h8
        && wcnt_ff == 2'h2 && !start && !stop;
    assign fire = I_WDOG_EXPIRE && pulse_ff == '0;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            for (int i = 0; i < N_REG; i++) begin
                regs_ff[i] <= REG_RST[i];
            end
            regs_ff[REG_FB] <= {REV_ID, VENDOR_ID};
        end else begin
            if (wr) begin
                regs_ff[idx_ff] <= sh_ff;
            end
            if (fire) begin
                regs_ff[REG_STEP] <= 8'h00;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < N_REG; i++) begin
            reg_rd[i] = regs_ff[i];
        end
        reg_rd[REG_CPU][B1_RO_FS2] = ~strap_ff.fs[2];
        reg_rd[REG_SDR][B3_RO_FS0] = ~strap_ff.fs[0];
        reg_rd[REG_STRAP][B4_RO_FS1] = ~strap_ff.fs[1];
        reg_rd[REG_STRAP][B4_RO_FS3] = ~strap_ff.fs[3];
    end
    assign rd_data = reg_rd[idx_ff];

    // a later expiry during the pulse is dropped
    assign nxt_pulse = fire ? PW'(PULSE_CYC)
        : (pulse_ff != '0 ? pulse_ff - PW'(1) : pulse_ff);
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            pulse_ff <= '0;
            wd_oe_n_ff <= 1'b1;
            wd_out_ff <= 1'b0;
            fb_ff <= FB_NONE;
        end else begin
            pulse_ff <= nxt_pulse;
            wd_oe_n_ff <= (nxt_pulse == '0);
            if (wr && idx_ff == 3'(REG_FSEL)) begin
                fb_ff <= FB_NONE;
            end
            if (fire) begin
                fb_ff <= (fb_ff == FB_NONE) ? FB_CODE : FB_STRAP;
            end
        end
    end

    always_comb begin
        nxt_freq.step = regs_ff[REG_STEP];
        if (fb_ff == FB_CODE) begin
            nxt_freq.code = regs_ff[REG_FB][7:3];
        end else if (fb_ff == FB_NONE && regs_ff[REG_FSEL][B0_SWSEL]) begin
            nxt_freq.code = {regs_ff[REG_FSEL][B0_MSB],
                regs_ff[REG_FSEL][7:4]};
        end else begin
            nxt_freq.code = {regs_ff[REG_FSEL][B0_MSB], strap_ff.fs};
        end
    end
    assign mag_ofs = 13'(STEP_UNIT) * 13'(regs_ff[REG_STEP][6:0]);
    // whole values change in one edge so no mixed code is ever seen
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            freq_ff <= '0;
            spread_ff <= 1'b1;
            ofs_ff <= '0;
        end else begin
            freq_ff <= nxt_freq;
            spread_ff <= regs_ff[REG_FSEL][B0_SPREAD];
            ofs_ff <= regs_ff[REG_STEP][7] ? -$signed(mag_ofs)
                : $signed(mag_ofs);
        end
    end

    assign halt = ~strap_ff.mode & ~pin2_s;
    assign en_req = {regs_ff[REG_PERI][1:0], regs_ff[REG_PERI][4],
        regs_ff[REG_SDR][4], regs_ff[REG_SDR][5],
        {4{regs_ff[REG_SDR][2]}}, {4{regs_ff[REG_SDR][1]}},
        {4{regs_ff[REG_SDR][0]}}, regs_ff[REG_CPU][3],
        regs_ff[REG_PCI][4:0], regs_ff[REG_PCI][6],
        regs_ff[REG_CPU][1:0]} & ~(HALT_MASK & {N_OUT{halt}});
    assign src_vec = {{3{src_s[5]}}, src_s[4], src_s[3],
        {13{src_s[SRC_SDR]}}, {6{src_s[1]}}, {2{src_s[0]}}};

    for (genvar i = 0; i < N_OUT; i++) begin : g_out
        logic live_ff, out_ff, oe_n_ff;
        always_ff @(posedge I_CLK) begin
            if (I_RST) begin
                live_ff <= 1'b0;
                out_ff <= 1'b0;
                oe_n_ff <= 1'b1;
            end else begin
                if (!src_vec[i]) begin
                    live_ff <= en_req[i];
                end
                out_ff <= src_vec[i] & live_ff & strap_done_ff;
                oe_n_ff <= regs_ff[REG_FSEL][B0_TRI]
                    | (STRAP_PINS[i] & ~strap_done_ff)
                    | (i == OUT_REF_A && !strap_ff.mode);
            end
        end
        assign clk_q[i] = out_ff;
        assign oe_q[i] = oe_n_ff;
    end

    assign O_SDA = sda_out_ff;
    assign O_SDA_OE_N = sda_oe_n_ff;
    assign O_CLK = clk_q;
    assign O_CLK_OE_N = oe_q;
    assign O_WDOG_RESET_N = wd_out_ff;
    assign O_WDOG_RESET_N_OE_N = wd_oe_n_ff;
    assign O_FREQ = freq_ff;
    assign O_SPREAD = spread_ff;
    assign O_CPU_OFS = ofs_ff;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    AST_ADDR_ACK: assert property (st_ff == ST_ADDR && scl_fall && !start
        && !stop && cnt_ff == 4'h8 && sh_ff[7:1] == SLAVE_ADDR
        |=> !O_SDA_OE_N) else $error("no ack to own address");
    AST_WR_STORE: assert property (wr && !fire
        |=> regs_ff[$past(idx_ff)] == $past(sh_ff)) else $error("write lost");
    AST_STEP_CLR: assert property (fire |=> regs_ff[REG_STEP] == 8'h00
        ##1 O_FREQ.step == 8'h00) else $error("step not cleared");
    AST_WD_PULSE: assert property (fire
        |=> !O_WDOG_RESET_N_OE_N [*8]) else $error("reset pulse short");
    AST_HALT_LOW: assert property (!g_out[3].live_ff
        |=> !O_CLK[3]) else $error("stopped clock ran");
    AST_TRISTATE: assert property (regs_ff[REG_FSEL][B0_TRI]
        |=> &O_CLK_OE_N) else $error("outputs not tristated");
    AST_STRAP_HOLD: assert property (strap_done_ff
        |=> $stable(strap_ff)) else $error("strap changed");
    AST_FB_CODE: assert property (fb_ff == FB_CODE
        |=> O_FREQ.code == $past(regs_ff[REG_FB][7:3]))
        else $error("fall-back code not used");
    AST_READBACK: assert property (reg_rd[REG_CPU][B1_RO_FS2]
        != strap_ff.fs[2]) else $error("strap readback wrong");
    CV_WRITE: cover property (wr);
    CV_READ: cover property (st_ff == ST_TX ##1 st_ff == ST_TXACK);
    CV_SECOND_FIRE: cover property (fire && fb_ff == FB_CODE);
endmodule

// ===== clkgen_ctrl_tb_top.sv
// self-checking bench for the clock generator control block
`timescale 1ns/1ps
module clkgen_ctrl_tb_top import clkgen_pkg::*; ;
    localparam int PCYC = 20;
    localparam int LIMIT = 60000;
    // identity nibbles are the arbitrary design defaults
    localparam logic [7:0] RST_EXP [8] = '{8'h02, 8'h7F, 8'hFF, 8'hBF,
        8'hF7, 8'hFF, 8'h5A, 8'h00};
    localparam logic [7:0] WR [8] = '{8'hE8, 8'hFF, 8'hFE, 8'hFE,
        8'h00, 8'hFF, 8'hA8, 8'h92};
    localparam logic [7:0] RD_EXP [8] = '{8'hE8, 8'h7F, 8'hFE, 8'hBE,
        8'h02, 8'hFF, 8'hA8, 8'h92};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic expire = 1'b0;
    logic pin2 = 1'b1;
    logic [N_SRC-1:0] src = '0;
    logic sda_o, sda_oe_n, scl, sda_rel, wd_o, wd_oe_n, spread, ok;
    logic [N_OUT-1:0] clk_o, clk_oe_n;
    freq_t freq;
    logic signed [12:0] ofs;
    logic [7:0] d [8];
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    // open-drain line with pull-up
    wire sda = sda_rel & (sda_oe_n | sda_o);
    clkgen_ctrl #(.PULSE_CYC(PCYC)) u_clkgen_ctrl (
        .I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda),
        .O_SDA(sda_o), .O_SDA_OE_N(sda_oe_n), .I_STRAP(4'h7),
        .I_MODE(1'b0), .I_PIN2(pin2), .I_SRC_CLK(src),
        .I_WDOG_EXPIRE(expire), .O_CLK(clk_o), .O_CLK_OE_N(clk_oe_n),
        .O_WDOG_RESET_N(wd_o), .O_WDOG_RESET_N_OE_N(wd_oe_n),
        .O_FREQ(freq), .O_SPREAD(spread), .O_CPU_OFS(ofs));
    clkgen_host u_clkgen_host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_rel(sda_rel));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        #1;
        cyc++;
        src = {N_SRC{cyc[2]}};
        if (cyc == LIMIT) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got,
                exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic t_reset_read();
        u_clkgen_host.frame(8'hD3, 8, d, ok);
        chk(ok, 1);
        foreach (d[i]) chk(d[i], RST_EXP[i]);
        chk(freq, 13'h0700);
        chk(spread, 1);
        chk(clk_oe_n[3], 0);
        chk(clk_oe_n[24], 1);
        $display("test reset_read done");
    endtask
    task automatic t_bad_addr();
        u_clkgen_host.frame(8'hA0, 1, d, ok);
        chk(ok, 0);
        $display("test bad_addr done");
    endtask
    task automatic t_write_read();
        d = WR;
        u_clkgen_host.frame(8'hD2, 8, d, ok);
        chk(ok, 1);
        u_clkgen_host.frame(8'hD3, 8, d, ok);
        foreach (d[i]) chk(d[i], RD_EXP[i]);
        chk(freq, {5'h0E, 8'h92});
        chk(ofs, 32'hFFFFFE74);
        chk(spread, 0);
        $display("test write_read done");
    endtask
    task automatic t_halt();
        logic [N_OUT-1:0] seen;
        pin2 = 1'b0;
        repeat (8) @(posedge clk);
        seen = '0;
        repeat (64) begin
            @(posedge clk);
            #1;
            seen |= clk_o;
        end
        chk(seen[8:2], 7'h41);
        pin2 = 1'b1;
        repeat (8) @(posedge clk);
        seen = '0;
        repeat (64) begin
            @(posedge clk);
            #1;
            seen |= clk_o;
        end
        chk(seen[8:2], 7'h7D);
        chk(seen[20:9], 12'hFF0);
        $display("test halt done");
    endtask
    task automatic fire(input logic [4:0] code);
        int n;
        n = 1;
        expire = 1'b1;
        @(posedge clk);
        #1;
        expire = 1'b0;
        @(posedge clk);
        #1;
        chk(wd_oe_n, 0);
        chk(wd_o, 0);
        while (wd_oe_n === 1'b0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, PCYC);
        chk(freq, {code, 8'h00});
        chk(ofs, 0);
    endtask
    task automatic t_wdog();
        fire(5'h15);
        fire(5'h07);
        $display("test wdog done");
    endtask
    task automatic t_tristate();
        d[0] = 8'h09;
        u_clkgen_host.frame(8'hD2, 1, d, ok);
        u_clkgen_host.frame(8'hD3, 8, d, ok);
        chk(d[0], 8'h09);
        chk(d[7], 8'h00);
        chk(freq, 13'h0000);
        chk(clk_oe_n, {N_OUT{1'b1}});
        $display("test tristate done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset_read();
        t_bad_addr();
        t_write_read();
        t_halt();
        t_wdog();
        t_tristate();
        wrap_up();
    end
endmodule

// ===== clkgen_host.sv
// serial bus host model driving control frames into the block
`timescale 1ns/1ps
module clkgen_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_rel
);
    initial begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // data moves well after scl falls so it never looks like start or stop
    task automatic bit_slot(input logic v, output logic s);
        wt(4);
        o_sda_rel = v;
        wt(12);
        o_scl = 1'b1;
        wt(16);
        s = i_sda;
        o_scl = 1'b0;
    endtask
    // write: command and count bytes precede data; read: data follows address
    task automatic frame(input logic [7:0] adr, input int n,
            inout logic [7:0] d [8], output logic ok);
        logic [7:0] b;
        logic a;
        int len;
        len = adr[0] ? n + 1 : n + 3;
        ok = 1'b1;
        wt(8);
        o_sda_rel = 1'b0;
        wt(16);
        o_scl = 1'b0;
        for (int j = 0; j < len; j++) begin
            b = (j == 0) ? adr : (j == 2) ? 8'(n) : 8'h00;
            if (!adr[0] && j > 2) b = d[j - 3];
            if (adr[0] && j > 0) b = 8'hFF;
            for (int i = 7; i >= 0; i--) bit_slot(b[i], b[i]);
            if (adr[0] && j > 0) d[j - 1] = b;
            bit_slot((adr[0] && j > 0 && j < n) ? 1'b0 : 1'b1, a);
            if (!(adr[0] && j > 0)) ok = ok & !a;
            if (!ok) break;
        end
        wt(4);
        o_sda_rel = 1'b0;
        wt(16);
        o_scl = 1'b1;
        wt(16);
        o_sda_rel = 1'b1;
    endtask
endmodule

// ===== clkgen_pkg.sv
// constants and types shared by the clock generator control block
package clkgen_pkg;
    localparam int CLK_KHZ = 200000;
    localparam int WDOG_PULSE_MS = 500;
    localparam int WDOG_PULSE_CYC = WDOG_PULSE_MS * CLK_KHZ;
    localparam int STRAP_WAIT = 3;
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam int N_REG = 8;
    localparam int N_OUT = 26;
    localparam int N_SRC = 6;
    localparam int REG_FSEL = 0;
    localparam int REG_CPU = 1;
    localparam int REG_PCI = 2;
    localparam int REG_SDR = 3;
    localparam int REG_STRAP = 4;
    localparam int REG_PERI = 5;
    localparam int REG_FB = 6;
    localparam int REG_STEP = 7;
    localparam logic [7:0] REG_RST [N_REG] = '{8'h02, 8'h7F, 8'hFF, 8'hBF,
        8'hF5, 8'hFF, 8'h00, 8'h00};
    localparam int B0_TRI = 0;
    localparam int B0_SPREAD = 1;
    localparam int B0_MSB = 2;
    localparam int B0_SWSEL = 3;
    localparam int B1_RO_FS2 = 7;
    localparam int B3_RO_FS0 = 6;
    localparam int B4_RO_FS1 = 3;
    localparam int B4_RO_FS3 = 1;
    localparam logic [5:0] STEP_UNIT = 6'h16;
    localparam logic [3:0] STRAP_PULL = 4'h7;
    localparam int SRC_SDR = 2;
    localparam int OUT_REF_A = 24;
    localparam logic [N_OUT-1:0] HALT_MASK = 26'h00000F8;
    localparam logic [N_OUT-1:0] STRAP_PINS = 26'h260000C;
    typedef struct packed {
        logic mode;
        logic [3:0] fs;
    } strap_t;
    typedef struct packed {
        logic [4:0] code;
        logic [7:0] step;
    } freq_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_AACK = 3'h3, ST_RX = 3'h2,
        ST_RXACK = 3'h6, ST_TX = 3'h7, ST_TXACK = 3'h5
    } i2c_st_t;
    typedef enum logic [1:0] {
        FB_NONE = 2'h0, FB_CODE = 2'h1, FB_STRAP = 2'h3
    } fb_st_t;
endpackage
